// ---- inc/lcs_consts.svh ----
// Constants of the charge sequencer: register offsets, field positions, reset
// values and timer counts. Assumes a 100 MHz mclk and a 32 kHz slow tick.
// How it works
// - Safety timer code picks 3, 5, 8, 12 hours
// - Watchdog code 11 gives 160 seconds
// - Bad input turns pass switch off at once
// - Good input qualified for 200 us first
// - Supply rising above UVLO resets all registers
// - Trickle current below precharge threshold, two-bit field
// - One hour precharge timeout stops charge, faults
// - Above precharge threshold enter fast charge
// - Full-charge voltage moves charge to CV
// - End current equals trickle, or twice it
// - Terminate after 500 us at end current
// - Timer option reports done, keeps tapering
// - Termination off keeps reporting charging status
// - Safety timer expiry ends cycle with fault
// - Power cycle, enable or recharge starts cycle
// - After done, low battery restarts charge
// - Recharge only with termination on, option off
// - Battery over-voltage suspends charge, raises fault
// - Hot die requests charge current reduction
// - Watchdog expiry restores defaults; write returns host
// - Safety timer restarts on cycle or 0-to-1 writes
// - Double timer runs half rate under power limiting
`ifndef LCS_CONSTS_SVH
`define LCS_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define LCS_OFF_CTRL 12'h000
`define LCS_OFF_CURR 12'h004
`define LCS_OFF_VOLT 12'h008
`define LCS_OFF_TIMER 12'h00c
`define LCS_OFF_THERM 12'h010
`define LCS_OFF_STAT 12'h014

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define LCS_CTRL_CHG_EN 3
`define LCS_CTRL_WD_KICK 6
`define LCS_CTRL_SW_RST 7
`define LCS_CURR_RANGE 4
`define LCS_TMR_KEEP 0
`define LCS_TMR_SAFE_LO 1
`define LCS_TMR_SAFE_EN 3
`define LCS_TMR_WD_LO 4
`define LCS_TMR_TERM_EN 6
`define LCS_THERM_DBL 6
`define LCS_CTRL_RST 8'h08
`define LCS_CURR_RST 8'h09
`define LCS_TRK_RST 8'h02
`define LCS_VOLT_RST 8'ha0
`define LCS_TIMER_RST 8'h6a
`define LCS_THERM_RST 8'h03

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define LCS_CLK_HZ 100000000
`define LCS_SLOW_HZ 32000
`define LCS_QUAL_US 200
`define LCS_EOC_US 500
`define LCS_QUAL_CYC ((`LCS_QUAL_US * (`LCS_CLK_HZ / 1000000)))
`define LCS_EOC_TICKS ((`LCS_EOC_US * `LCS_SLOW_HZ + 999999) / 1000000)
`define LCS_PRE_S 3600
`define LCS_WD_160_S 160
`define LCS_WD_80_S 80
`define LCS_WD_40_S 40
`define LCS_SAFE3_S 10800
`define LCS_SAFE5_S 18000
`define LCS_SAFE8_S 28800
`define LCS_SAFE12_S 43200

`endif

// ---- inc/lcs_pkg.sv ----
// Types of the charge sequencer.
// Assumes lcs_consts.svh supplies all numbers.
package lcs_pkg;

    typedef enum logic [2:0] {
        LCS_IDLE = 3'b000,
        LCS_TRICKLE = 3'b001,
        LCS_FAST = 3'b011,
        LCS_CV = 3'b010,
        LCS_DONE = 3'b110,
        LCS_FAULT = 3'b111
    } lcs_phase_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] curr;
        logic [7:0] trk;
        logic [7:0] volt;
        logic [7:0] timer;
        logic [7:0] therm;
        logic hostMode;
        lcs_phase_t phase;
        logic chgDone;
        logic preFault;
        logic safeFault;
        logic ovFault;
        logic [15:0] qualCnt;
        logic inputOk;
        logic [11:0] divCnt;
        logic tick;
        logic halfTick;
        logic [9:0] secFrac;
        logic secTick;
        logic [15:0] safeSec;
        logic [12:0] preSec;
        logic [7:0] wdSec;
        logic [4:0] eocCnt;
        logic [2:0] vinSync;
        logic [2:0] vinHiSync;
        logic vinPresent;
        logic [31:0] prdata;
    } lcs_state_t;

endpackage : lcs_pkg

// ---- design/lcs_charge_sequencer.sv ----
// Charge sequencer for a single-cell lithium charger with APB register access.
// Assumes comparator inputs arrive asynchronously and the analog loops obey
// the current, voltage and reduction requests driven here.
`timescale 1ns/100ps
`include "lcs_consts.svh"

module lcs_charge_sequencer
    import lcs_pkg::*;
#(
    parameter int SLOW_DIV = `LCS_CLK_HZ / `LCS_SLOW_HZ,
    parameter int TICKS_PER_SEC = `LCS_SLOW_HZ
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic inputInRange,
    input wire logic batteryAbovePrecharge,
    input wire logic batteryAtFull,
    input wire logic batteryBelowRecharge,
    input wire logic batteryOverVoltage,
    input wire logic currentAtEndOfCharge,
    input wire logic powerLimitActive,
    input wire logic supplyAboveUvlo,
    output logic inputPassSwitchOn,
    output logic chargeOn,
    output logic [1:0] chargeMode,
    output logic [4:0] fastChargeCurrent,
    output logic [1:0] trickleCurrent,
    output logic [5:0] fullChargeVoltage,
    output logic recharge_margin,
    output logic endOfChargeDouble,
    output logic [1:0] thermalThreshold,
    output logic [2:0] phase,
    output logic chargeDoneStatus,
    output logic timeoutFault,
    output logic batteryOvFault
);

    // ------------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------------
    if (SLOW_DIV < 2 || SLOW_DIV > 4095 || TICKS_PER_SEC < 1 || TICKS_PER_SEC > 1023) begin : g_chk
        $error("lcs_charge_sequencer: divider parameters out of range");
    end

    localparam logic [11:0] DIV_LAST = 12'(SLOW_DIV - 1);
    localparam logic [9:0] SEC_LAST = 10'(TICKS_PER_SEC - 1);
    localparam logic [15:0] QUAL_LAST = 16'(`LCS_QUAL_CYC - 1);
    localparam logic [4:0] EOC_LAST = 5'(`LCS_EOC_TICKS - 1);
    localparam logic [12:0] PRE_LAST = 13'(`LCS_PRE_S - 1);

    lcs_state_t cur_ff, nxt_cur;

    logic [15:0] safeLimit;
    logic [7:0] wdLimit;
    logic wrStb;
    logic restartSafe;
    logic startCycle;
    logic vinOk;
    logic batLow;
    logic batFull;
    logic batRech;
    logic batOv;
    logic eocCur;
    logic pwrLim;
    logic supUp;
    logic wdKick;
    logic supWasUp_ff;
    logic [2:0] supSync_ff;
    logic [2:0] s0Sync_ff, s1Sync_ff, s2Sync_ff, s3Sync_ff, s4Sync_ff, s5Sync_ff;

    // ------------------------------------------------------------------------
    // Input synchronisers: three stages, a level counts as high only while stages 2 and 3 are both high
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s0Sync_ff <= 3'h0;
            s1Sync_ff <= 3'h0;
            s2Sync_ff <= 3'h0;
            s3Sync_ff <= 3'h0;
            s4Sync_ff <= 3'h0;
            s5Sync_ff <= 3'h0;
            supSync_ff <= 3'h0;
            supWasUp_ff <= 1'b0;
        end else begin
            s0Sync_ff <= {s0Sync_ff[1:0], batteryAbovePrecharge};
            s1Sync_ff <= {s1Sync_ff[1:0], batteryAtFull};
            s2Sync_ff <= {s2Sync_ff[1:0], batteryBelowRecharge};
            s3Sync_ff <= {s3Sync_ff[1:0], batteryOverVoltage};
            s4Sync_ff <= {s4Sync_ff[1:0], currentAtEndOfCharge};
            s5Sync_ff <= {s5Sync_ff[1:0], powerLimitActive};
            supSync_ff <= {supSync_ff[1:0], supplyAboveUvlo};
            if (supSync_ff[2] == supSync_ff[1]) begin
                supWasUp_ff <= supSync_ff[2];
            end
        end
    end

    assign batLow = !(s0Sync_ff[2] & s0Sync_ff[1]);
    assign batFull = s1Sync_ff[2] & s1Sync_ff[1];
    assign batRech = s2Sync_ff[2] & s2Sync_ff[1];
    assign batOv = s3Sync_ff[2] & s3Sync_ff[1];
    assign eocCur = s4Sync_ff[2] & s4Sync_ff[1];
    assign pwrLim = s5Sync_ff[2] & s5Sync_ff[1];
    assign supUp = (supSync_ff[2] & supSync_ff[1]) & !supWasUp_ff;
    // Input-valid is synchronised here; the pass switch uses the raw input so it opens at once.
    assign vinOk = cur_ff.vinSync[2] & cur_ff.vinSync[1];

    assign wrStb = psel & penable & pwrite;
    assign wdKick = wrStb && paddr == `LCS_OFF_CTRL && pwdata[`LCS_CTRL_WD_KICK];

    always_comb begin
        case (cur_ff.timer[`LCS_TMR_SAFE_LO +: 2])
            2'b00: safeLimit = 16'(`LCS_SAFE3_S - 1);
            2'b01: safeLimit = 16'(`LCS_SAFE5_S - 1);
            2'b10: safeLimit = 16'(`LCS_SAFE8_S - 1);
            default: safeLimit = 16'(`LCS_SAFE12_S - 1);
        endcase
        case (cur_ff.timer[`LCS_TMR_WD_LO +: 2])
            2'b01: wdLimit = 8'(`LCS_WD_40_S - 1);
            2'b10: wdLimit = 8'(`LCS_WD_80_S - 1);
            2'b11: wdLimit = 8'(`LCS_WD_160_S - 1);
            default: wdLimit = 8'hff;
        endcase
    end

    // ------------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------------
    always_comb begin
        nxt_cur = cur_ff;
        restartSafe = 1'b0;
        startCycle = 1'b0;
        nxt_cur.vinSync = {cur_ff.vinSync[1:0], inputInRange};
        nxt_cur.vinHiSync = {cur_ff.vinHiSync[1:0], inputInRange};

        // Slow clock tick and seconds; all timers but input qualification derive from these.
        nxt_cur.tick = 1'b0;
        nxt_cur.secTick = 1'b0;
        if (cur_ff.divCnt == DIV_LAST) begin
            nxt_cur.divCnt = 12'h000;
            nxt_cur.tick = 1'b1;
        end else begin
            nxt_cur.divCnt = cur_ff.divCnt + 12'h001;
        end
        // The half-rate gate alternates per second, not per slow tick.
        if (cur_ff.secTick) begin
            nxt_cur.halfTick = ~cur_ff.halfTick;
        end
        if (cur_ff.tick) begin
            if (cur_ff.secFrac == SEC_LAST) begin
                nxt_cur.secFrac = 10'h000;
                nxt_cur.secTick = 1'b1;
            end else begin
                nxt_cur.secFrac = cur_ff.secFrac + 10'h001;
            end
        end

        // Input qualification.
        if (!vinOk) begin
            nxt_cur.inputOk = 1'b0;
            nxt_cur.qualCnt = 16'h0000;
        end else if (!cur_ff.inputOk) begin
            if (cur_ff.qualCnt == QUAL_LAST) begin
                nxt_cur.inputOk = 1'b1;
                startCycle = 1'b1;
            end else begin
                nxt_cur.qualCnt = cur_ff.qualCnt + 16'h0001;
            end
        end

        // Register writes; any write puts the device in host mode unless a software reset or a watchdog expiry in the same cycle clears it.
        if (wrStb) begin
            nxt_cur.hostMode = 1'b1;
            if (paddr == `LCS_OFF_CTRL) begin
                nxt_cur.ctrl = pwdata[7:0] & ~8'hc0;
                if (pwdata[`LCS_CTRL_CHG_EN] && !cur_ff.ctrl[`LCS_CTRL_CHG_EN]) begin
                    restartSafe = 1'b1;
                    startCycle = 1'b1;
                end
                if (pwdata[`LCS_CTRL_WD_KICK]) begin
                    nxt_cur.wdSec = 8'h00;
                end
            end else if (paddr == `LCS_OFF_CURR) begin
                nxt_cur.curr = pwdata[7:0];
                nxt_cur.trk = {6'h00, pwdata[9:8]};
            end else if (paddr == `LCS_OFF_VOLT) begin
                nxt_cur.volt = pwdata[7:0];
            end else if (paddr == `LCS_OFF_TIMER) begin
                nxt_cur.timer = pwdata[7:0];
                if (pwdata[`LCS_TMR_SAFE_EN] && !cur_ff.timer[`LCS_TMR_SAFE_EN]) begin
                    restartSafe = 1'b1;
                end
            end else if (paddr == `LCS_OFF_THERM) begin
                nxt_cur.therm = pwdata[7:0];
            end
        end

        // Watchdog, paused without input.
        if (cur_ff.secTick && cur_ff.hostMode && vinOk && !wdKick
                && cur_ff.timer[`LCS_TMR_WD_LO +: 2] != 2'b00) begin
            if (cur_ff.wdSec == wdLimit) begin
                nxt_cur.ctrl = `LCS_CTRL_RST;
                nxt_cur.curr = `LCS_CURR_RST;
                nxt_cur.trk = `LCS_TRK_RST;
                nxt_cur.volt = `LCS_VOLT_RST;
                nxt_cur.timer = `LCS_TIMER_RST;
                nxt_cur.therm = `LCS_THERM_RST;
                nxt_cur.hostMode = 1'b0;
                nxt_cur.wdSec = 8'h00;
            end else begin
                nxt_cur.wdSec = cur_ff.wdSec + 8'h01;
            end
        end

        // Software reset restores defaults and restarts the safety timer.
        if (wrStb && paddr == `LCS_OFF_CTRL && pwdata[`LCS_CTRL_SW_RST]) begin
            nxt_cur.ctrl = `LCS_CTRL_RST;
            nxt_cur.curr = `LCS_CURR_RST;
            nxt_cur.trk = `LCS_TRK_RST;
            nxt_cur.volt = `LCS_VOLT_RST;
            nxt_cur.timer = `LCS_TIMER_RST;
            nxt_cur.therm = `LCS_THERM_RST;
            nxt_cur.hostMode = 1'b0;
            restartSafe = 1'b1;
        end

        // Auto-recharge after termination.
        if (cur_ff.phase == LCS_DONE && batRech && cur_ff.inputOk
                && cur_ff.timer[`LCS_TMR_TERM_EN] && !cur_ff.timer[`LCS_TMR_KEEP]) begin
            startCycle = 1'b1;
        end

        // Charge phase sequencer.
        case (cur_ff.phase)
            LCS_TRICKLE: begin
                if (cur_ff.secTick) begin
                    nxt_cur.preSec = cur_ff.preSec + 13'h0001;
                end
                if (!batLow) begin
                    nxt_cur.phase = LCS_FAST;
                    restartSafe = 1'b1;
                end else if (cur_ff.secTick && cur_ff.preSec == PRE_LAST) begin
                    nxt_cur.phase = LCS_FAULT;
                    nxt_cur.preFault = 1'b1;
                end
            end
            LCS_FAST, LCS_CV: begin
                if (cur_ff.phase == LCS_FAST && batFull) begin
                    nxt_cur.phase = LCS_CV;
                end
                if (cur_ff.phase == LCS_CV && eocCur) begin
                    if (cur_ff.tick) begin
                        if (cur_ff.eocCnt != EOC_LAST) begin
                            nxt_cur.eocCnt = cur_ff.eocCnt + 5'h01;
                        end else if (cur_ff.timer[`LCS_TMR_TERM_EN]) begin
                            nxt_cur.chgDone = 1'b1;
                            if (!cur_ff.timer[`LCS_TMR_KEEP]) begin
                                nxt_cur.phase = LCS_DONE;
                            end
                        end
                    end
                end else begin
                    nxt_cur.eocCnt = 5'h00;
                end
                if (cur_ff.secTick && cur_ff.timer[`LCS_TMR_SAFE_EN]
                        && !(pwrLim && cur_ff.therm[`LCS_THERM_DBL] && cur_ff.halfTick)) begin
                    if (cur_ff.safeSec >= safeLimit && !cur_ff.chgDone) begin
                        nxt_cur.phase = LCS_FAULT;
                        nxt_cur.safeFault = 1'b1;
                    end else begin
                        nxt_cur.safeSec = cur_ff.safeSec + 16'h0001;
                    end
                end
            end
            default: begin
            end
        endcase

        if (startCycle && cur_ff.ctrl[`LCS_CTRL_CHG_EN] | (wrStb && paddr == `LCS_OFF_CTRL)) begin
            nxt_cur.phase = LCS_TRICKLE;
            nxt_cur.preSec = 13'h0000;
            nxt_cur.chgDone = 1'b0;
            nxt_cur.preFault = 1'b0;
            nxt_cur.safeFault = 1'b0;
            restartSafe = 1'b1;
        end
        if (restartSafe) begin
            nxt_cur.safeSec = 16'h0000;
        end
        if (!nxt_cur.inputOk || !nxt_cur.ctrl[`LCS_CTRL_CHG_EN]) begin
            nxt_cur.phase = LCS_IDLE;
        end

        // Over-voltage suspends charge until the fault clears; fault sticks until a read.
        if (batOv) begin
            nxt_cur.ovFault = 1'b1;
        end else if (psel && penable && !pwrite && paddr == `LCS_OFF_STAT) begin
            nxt_cur.ovFault = 1'b0;
        end

        // Read data path.
        if (psel && !penable && !pwrite) begin
            if (paddr == `LCS_OFF_CTRL) begin
                nxt_cur.prdata = {24'h000000, cur_ff.ctrl};
            end else if (paddr == `LCS_OFF_CURR) begin
                nxt_cur.prdata = {22'h000000, cur_ff.trk[1:0], cur_ff.curr};
            end else if (paddr == `LCS_OFF_VOLT) begin
                nxt_cur.prdata = {24'h000000, cur_ff.volt};
            end else if (paddr == `LCS_OFF_TIMER) begin
                nxt_cur.prdata = {24'h000000, cur_ff.timer};
            end else if (paddr == `LCS_OFF_THERM) begin
                nxt_cur.prdata = {24'h000000, cur_ff.therm};
            end else if (paddr == `LCS_OFF_STAT) begin
                nxt_cur.prdata = {24'h000000, cur_ff.hostMode, cur_ff.ovFault,
                    cur_ff.safeFault, cur_ff.preFault, cur_ff.chgDone,
                    cur_ff.phase};
            end else begin
                nxt_cur.prdata = 32'h00000000;
            end
        end
    end

    // ------------------------------------------------------------------------
    // State register; a fresh supply rise reloads every default
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cur_ff <= '0;
            cur_ff.ctrl <= `LCS_CTRL_RST;
            cur_ff.curr <= `LCS_CURR_RST;
            cur_ff.trk <= `LCS_TRK_RST;
            cur_ff.volt <= `LCS_VOLT_RST;
            cur_ff.timer <= `LCS_TIMER_RST;
            cur_ff.therm <= `LCS_THERM_RST;
        end else if (supUp) begin
            cur_ff <= '0;
            cur_ff.ctrl <= `LCS_CTRL_RST;
            cur_ff.curr <= `LCS_CURR_RST;
            cur_ff.trk <= `LCS_TRK_RST;
            cur_ff.volt <= `LCS_VOLT_RST;
            cur_ff.timer <= `LCS_TIMER_RST;
            cur_ff.therm <= `LCS_THERM_RST;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign prdata = cur_ff.prdata;
    assign pready = psel & penable;
    assign pslverr = 1'b0;
    assign inputPassSwitchOn = cur_ff.inputOk & inputInRange;
    assign chargeOn = (cur_ff.phase == LCS_TRICKLE || cur_ff.phase == LCS_FAST
        || cur_ff.phase == LCS_CV) && !cur_ff.ovFault;
    assign chargeMode = cur_ff.phase == LCS_TRICKLE ? 2'b01 :
        (cur_ff.phase == LCS_CV ? 2'b11 : 2'b10);
    assign fastChargeCurrent = cur_ff.curr[4:0];
    assign trickleCurrent = cur_ff.trk[1:0];
    assign fullChargeVoltage = cur_ff.volt[7:2];
    assign recharge_margin = cur_ff.volt[0];
    assign endOfChargeDouble = cur_ff.curr[`LCS_CURR_RANGE];
    assign thermalThreshold = cur_ff.therm[1:0];
    assign phase = cur_ff.phase;
    assign chargeDoneStatus = cur_ff.chgDone;
    assign timeoutFault = cur_ff.preFault | cur_ff.safeFault;
    assign batteryOvFault = cur_ff.ovFault;

endmodule : lcs_charge_sequencer

// ---- dv/lcs_sequencer_asserts.sv ----
// Port-level checks of the charge sequencer, bound to every instance.
// Assumes lcs_pkg is compiled first.
`timescale 1ns/100ps
module lcs_sequencer_asserts
    import lcs_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic inputInRange,
    input wire logic inputPassSwitchOn,
    input wire logic batteryOvFault,
    input wire logic chargeOn,
    input wire logic [1:0] chargeMode,
    input wire logic [2:0] phase,
    input wire logic chargeDoneStatus,
    input wire logic timeoutFault,
    input wire logic endOfChargeDouble,
    input wire logic [4:0] fastChargeCurrent
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_pass; !inputInRange |-> !inputPassSwitchOn; endproperty
    a_pass: assert property (p_pass) else $error("pass switch on");
    property p_ov; batteryOvFault |-> !chargeOn; endproperty
    a_ov: assert property (p_ov) else $error("charging in over-voltage");
    property p_trk; chargeOn && phase == LCS_TRICKLE |-> chargeMode == 2'b01; endproperty
    a_trk: assert property (p_trk) else $error("trickle mode wrong");
    property p_fast; chargeOn && phase == LCS_FAST |-> chargeMode == 2'b10; endproperty
    a_fast: assert property (p_fast) else $error("fast mode wrong");
    property p_cv; chargeOn && phase == LCS_CV |-> chargeMode == 2'b11; endproperty
    a_cv: assert property (p_cv) else $error("voltage mode wrong");
    property p_done; $rose(chargeDoneStatus) |-> $past(phase) inside {LCS_CV, LCS_DONE}; endproperty
    a_done: assert property (p_done) else $error("done outside voltage phase");
    property p_tmo; $rose(timeoutFault) |-> ##[0:1] (phase == LCS_FAULT && !chargeOn); endproperty
    a_tmo: assert property (p_tmo) else $error("timeout without stop");
    property p_eoc; endOfChargeDouble == fastChargeCurrent[4]; endproperty
    a_eoc: assert property (p_eoc) else $error("end current range wrong");
    c_done: cover property (phase == LCS_DONE);
    c_tmo: cover property ($rose(timeoutFault));
    c_ov: cover property (batteryOvFault && !chargeOn);
endmodule : lcs_sequencer_asserts

bind lcs_charge_sequencer lcs_sequencer_asserts u_chk (.*);

// ---- dv/lcs_battery_model.sv ----
// Cell and current-sense comparators facing the sequencer.
// Assumes charge rises one step a cycle while charging and leaks otherwise.
`timescale 1ns/100ps
module lcs_battery_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic dead,
    input wire logic chargeOn,
    input wire logic [1:0] chargeMode,
    output logic batteryAbovePrecharge,
    output logic batteryAtFull,
    output logic batteryBelowRecharge,
    output logic currentAtEndOfCharge
);
    logic [7:0] lvl_ff;
    // A dead cell never leaves the trickle region.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n || dead) begin
            lvl_ff <= 8'h00;
        end else if (chargeOn) begin
            lvl_ff <= (lvl_ff < 8'h50) ? lvl_ff + 8'h01 : lvl_ff;
        end else if (lvl_ff != 8'h00) begin
            lvl_ff <= lvl_ff - 8'h01;
        end
    end
    assign batteryAbovePrecharge = lvl_ff >= 8'h28;
    assign batteryAtFull = lvl_ff >= 8'h50;
    assign batteryBelowRecharge = lvl_ff < 8'h46;
    assign currentAtEndOfCharge = chargeMode == 2'b11 && batteryAtFull;
endmodule : lcs_battery_model

// ---- dv/lcs_charge_sequencer_tb_top.sv ----
// Self-checking bench of the charge sequencer over APB.
// Assumes one second is two mclk cycles through the shortened divider.
`timescale 1ns/100ps
`include "lcs_consts.svh"
module lcs_charge_sequencer_tb_top
    import lcs_pkg::*;
;
    logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, dead;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic inputInRange, batteryAbovePrecharge, batteryAtFull, batteryBelowRecharge;
    logic batteryOverVoltage, currentAtEndOfCharge, powerLimitActive, supplyAboveUvlo;
    logic inputPassSwitchOn, chargeOn, recharge_margin, endOfChargeDouble;
    logic chargeDoneStatus, timeoutFault, batteryOvFault;
    logic [1:0] chargeMode, trickleCurrent, thermalThreshold;
    logic [4:0] fastChargeCurrent;
    logic [5:0] fullChargeVoltage;
    logic [2:0] phase;
    int num_errors = 0;
    int checked = 0;
    int n;

    lcs_charge_sequencer #(.SLOW_DIV(2), .TICKS_PER_SEC(1)) u_dut (.*);
    lcs_battery_model u_batt (.*);

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk); // Idle cycle keeps the host access pace
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        {psel, penable} <= 2'b00;
    endtask : apb

    task automatic test_done;
        if (num_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        repeat (90000) @(posedge mclk);
        num_errors++;
        test_done();
    end

    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, dead, inputInRange} = '0;
        {batteryOverVoltage, powerLimitActive, supplyAboveUvlo} = 3'b001;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        inputInRange <= 1'b1;
        apb(1'b0, `LCS_OFF_CURR, 32'h0);
        chk("curr default", 32'h209, rd);
        chk("full voltage", 32'h28, fullChargeVoltage);
        chk("pass early", 32'h0, inputPassSwitchOn);
        for (n = 0; n < 21000 && inputPassSwitchOn !== 1'b1; n++) @(posedge mclk);
        chk("qual span", 32'h1, n > 19900);
        for (n = 0; n < 3000 && phase !== LCS_DONE; n++) @(posedge mclk);
        #1;
        chk("done phase", LCS_DONE, phase);
        chk("done flag", 32'h1, chargeDoneStatus);
        chk("stopped", 32'h0, chargeOn);
        for (n = 0; n < 500 && chargeOn !== 1'b1; n++) @(posedge mclk);
        chk("recharge", 32'h1, chargeOn);
        batteryOverVoltage <= 1'b1;
        repeat (8) @(posedge mclk);
        #1;
        chk("ov fault", 32'h1, batteryOvFault);
        chk("ov stop", 32'h0, chargeOn);
        batteryOverVoltage <= 1'b0;
        apb(1'b0, `LCS_OFF_STAT, 32'h0);
        chk("ov status", 32'h1, rd[6]);
        apb(1'b1, `LCS_OFF_CURR, 32'h310);
        repeat (2) @(posedge mclk);
        chk("ov cleared", 32'h0, batteryOvFault);
        chk("eoc double", 32'h1, endOfChargeDouble);
        chk("fast curr", 32'h10, fastChargeCurrent);
        chk("trickle", 32'h3, trickleCurrent);
        apb(1'b1, 12'h020, 32'hff);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped", 32'h0, rd);
        repeat (120) @(posedge mclk);
        apb(1'b1, `LCS_OFF_CTRL, 32'h48);
        repeat (100) @(posedge mclk);
        apb(1'b0, `LCS_OFF_CURR, 32'h0);
        chk("wd kicked", 32'h310, rd);
        repeat (400) @(posedge mclk);
        apb(1'b0, `LCS_OFF_CURR, 32'h0);
        chk("wd default", 32'h209, rd);
        dead <= 1'b1;
        rst_n <= 1'b0;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        for (n = 0; n < 40000 && timeoutFault !== 1'b1; n++) @(posedge mclk);
        #1;
        chk("pre timeout", 32'h1, n > 27000 && timeoutFault === 1'b1);
        chk("fault phase", LCS_FAULT, phase);
        chk("pass held", 32'h1, inputPassSwitchOn);
        inputInRange <= 1'b0;
        @(posedge mclk);
        #1;
        chk("pass drop", 32'h0, inputPassSwitchOn);
        test_done();
    end
endmodule : lcs_charge_sequencer_tb_top
